// File: inc/gen_ctl_pkg.sv
// Constants for the bridge general control register (upper half).
// Assumes a single 125 MHz core clock and config-space word access.
package gen_ctl_pkg;

  // ***************************************************************
  // Register location and reset
  // ***************************************************************
  localparam logic [11:0] GEN_CTL_OFFSET = 12'h0d4;  // Byte offset
  localparam logic [31:0] GEN_CTL_RESET = 32'h8206c000;  // Whole word

  // ***************************************************************
  // Field positions (upper half only)
  // ***************************************************************
  localparam int RETRY_HI = 31;
  localparam int RETRY_LO = 30;
  localparam int RSVD_HI = 29;
  localparam int RSVD_LO = 28;
  localparam int LOW_SWING_BIT = 27;
  localparam int PM_REV_BIT = 26;
  localparam int STRICT_BIT = 25;
  localparam int PREFETCH_BIT = 24;
  localparam int LINK_PM_DEF_BIT = 23;
  localparam int BUDGET_HI = 22;
  localparam int BUDGET_LO = 20;

  // ***************************************************************
  // Field encodings
  // ***************************************************************
  localparam logic [2:0] PM_REV_OLD = 3'h2;  // Version 010b
  localparam logic [2:0] PM_REV_NEW = 3'h3;  // Version 011b
  localparam logic [2:0] LOW_PRIO_STRICT = 3'h0;
  localparam logic [2:0] LOW_PRIO_DEFAULT = 3'h1;
  localparam logic [1:0] LINK_PM_OFF = 2'h0;
  localparam logic [1:0] LINK_PM_BOTH = 2'h3;
  localparam logic [1:0] RSVD_VALUE = 2'h0;

  // Slot budget action codes
  typedef enum logic [2:0] {
    BUDGET_IGNORE = 3'h0,
    BUDGET_SIGNAL = 3'h1,
    BUDGET_CLKSTOP = 3'h2,
    BUDGET_BOTH = 3'h3,
    BUDGET_UR = 3'h4
  } budget_action_type;

  // Retry timeout codes
  typedef enum logic [1:0] {
    RETRY_25US = 2'h0,
    RETRY_1MS = 2'h1,
    RETRY_25MS = 2'h2,
    RETRY_50MS = 2'h3
  } retry_sel_type;

  // ***************************************************************
  // Timing: figures in microseconds, core clock in MHz
  // ***************************************************************
  localparam int CORE_MHZ = 125;
  localparam int T_25US = 25;
  localparam int T_1MS_US = 1000;
  localparam int T_25MS_US = 25000;
  localparam int T_50MS_US = 50000;
  localparam int CYC_25US = T_25US * CORE_MHZ;
  localparam int CYC_1MS = T_1MS_US * CORE_MHZ;
  localparam int CYC_25MS = T_25MS_US * CORE_MHZ;
  localparam int CYC_50MS = T_50MS_US * CORE_MHZ;

endpackage

// File: design/retry_timer.sv
// Timer that bounds a configuration retry on the secondary bus.
// Assumes start is a one-cycle pulse; abort clears a running count.
`timescale 1ns/100ps
`default_nettype none
module retry_timer
  import gen_ctl_pkg::*;
#(
  parameter int CNT_W = 23
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic [CNT_W-1:0] limit_i,
  output logic expired_o
);

  logic [CNT_W-1:0] count_q;  // Cycles left
  logic running_q;  // Timer active

  // ***************************************************************
  // Countdown
  // ***************************************************************
  // Load on start, count down, flag when the count reaches zero
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || abort_i) begin
      count_q <= '0;
      running_q <= 1'b0;
    end else if (start_i) begin
      count_q <= limit_i;
      running_q <= 1'b1;
    end else if (running_q && count_q != '0) begin
      count_q <= count_q - 1'b1;
    end else begin
      running_q <= 1'b0;
    end
  end

  // Expiry is a one-cycle pulse at the end of the count
  assign expired_o = running_q && (count_q == '0) && !start_i && !abort_i;

endmodule
`default_nettype wire

// File: design/budget_decode.sv
// Decodes the slot budget action into its effects.
// Assumes the shortfall input is a level from the power logic.
`timescale 1ns/100ps
`default_nettype none
module budget_decode
  import gen_ctl_pkg::*;
(
  input wire logic [2:0] action_i,
  input wire logic short_i,
  output logic signal_o,
  output logic clkstop_o,
  output logic ur_mode_o
);

  // ***************************************************************
  // Action decode
  // ***************************************************************
  // Reserved codes act like ignore
  always_comb begin
    signal_o = 1'b0;
    clkstop_o = 1'b0;
    ur_mode_o = 1'b0;
    case (action_i)
      BUDGET_SIGNAL: begin
        signal_o = short_i;
      end
      BUDGET_CLKSTOP: begin
        clkstop_o = short_i;
      end
      BUDGET_BOTH: begin
        signal_o = short_i;
        clkstop_o = short_i;
      end
      BUDGET_UR: begin
        ur_mode_o = short_i;
      end
      default: begin
        signal_o = 1'b0;
      end
    endcase
  end

endmodule
`default_nettype wire

// File: design/bridge_general_control_reg.sv
// Upper half of the bridge general control register, with its effects.
// Assumes a config-space port: word write with byte enables, read data
// returned combinationally from register state.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// R1: Retry timeout field sets secondary retry time
// R2: Reserved bits 29:28 read zero
// R3: Low-swing bit halves transmitter amplitude
// R4: Revision bit selects version and soft-reset flag
// R5: Strict mode grants extended channel first
// R6: Strict bit sets low-priority group default
// R7: Prefetch force makes reads multiple-line
// R8: Link power default bit sets power-up control
// R9: Budget action asserts output or stops clocks
// R10: Code 100 answers unsupported except config and power-limit messages
// R11: Any reset restores field defaults
// R12: Ignore reserved writes; apply changes immediately
module bridge_general_control_reg
  import gen_ctl_pkg::*;
#(
  parameter int RETRY_W = 23
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic fund_reset_n_i,
  input wire logic global_reset_in_n_i,
  input wire logic por_n_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [11:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  input wire logic retry_start_i,
  input wire logic retry_done_i,
  output logic retry_expired_o,
  output logic tx_low_swing_o,
  output logic [2:0] pm_rev_field_o,
  output logic pm_no_soft_reset_o,
  input wire logic [2:0] low_prio_count_i,
  output logic [2:0] low_prio_default_o,
  output logic ext_vc_priority_o,
  input wire logic up_mem_read_i,
  output logic upstream_prefetch_read_force_o,
  output logic treat_as_multiple_o,
  output logic [1:0] link_pm_control_o,
  input wire logic slot_power_short_i,
  output logic budget_exceeded_out_o,
  output logic sec_clk_stop_o,
  input wire logic req_is_cfg_i,
  input wire logic req_is_spl_i,
  output logic req_unsupported_o
);

  // ***************************************************************
  // Register state
  // ***************************************************************
  logic [1:0] cfg_retry_timeout_sel_q;  // Retry time select
  logic low_swing_q;  // Transmit half amplitude
  logic pm_rev_select_q;  // Power management revision
  logic strict_q;  // Strict precedence enable
  logic upstream_prefetch_read_force_q;  // Force prefetching reads
  logic link_pm_default_sel_q;  // Link power default select
  logic [2:0] slot_budget_action_q;  // Slot budget action
  logic any_reset;  // Combined reset
  logic hit_wr;  // Write to this register
  logic [RETRY_W-1:0] retry_limit;  // Cycles for chosen timeout

  // Any of the reset sources returns the fields to default
  assign any_reset = !reset_n_i || !fund_reset_n_i || !global_reset_in_n_i
    || !por_n_i;  // see R11
  assign hit_wr = cfg_wr_i && (cfg_addr_i == GEN_CTL_OFFSET);

  // ***************************************************************
  // Byte 3: bits 31:24
  // ***************************************************************
  // Reserved bits 29:28 hold no state, writes to them are dropped
  always_ff @(posedge core_clk_i) begin
    if (any_reset) begin  // see R11
      cfg_retry_timeout_sel_q <= GEN_CTL_RESET[RETRY_HI:RETRY_LO];
      low_swing_q <= GEN_CTL_RESET[LOW_SWING_BIT];
      pm_rev_select_q <= GEN_CTL_RESET[PM_REV_BIT];
      strict_q <= GEN_CTL_RESET[STRICT_BIT];
      upstream_prefetch_read_force_q <= GEN_CTL_RESET[PREFETCH_BIT];
    end else if (hit_wr && cfg_be_i[3]) begin  // see R12
      cfg_retry_timeout_sel_q <= cfg_wdata_i[RETRY_HI:RETRY_LO];
      low_swing_q <= cfg_wdata_i[LOW_SWING_BIT];
      pm_rev_select_q <= cfg_wdata_i[PM_REV_BIT];
      strict_q <= cfg_wdata_i[STRICT_BIT];
      upstream_prefetch_read_force_q <= cfg_wdata_i[PREFETCH_BIT];
    end
  end

  // ***************************************************************
  // Byte 2: bits 23:20
  // ***************************************************************
  // Only the upper nibble of byte 2 belongs to this block
  always_ff @(posedge core_clk_i) begin
    if (any_reset) begin  // see R11
      link_pm_default_sel_q <= GEN_CTL_RESET[LINK_PM_DEF_BIT];
      slot_budget_action_q <= GEN_CTL_RESET[BUDGET_HI:BUDGET_LO];
    end else if (hit_wr && cfg_be_i[2]) begin
      link_pm_default_sel_q <= cfg_wdata_i[LINK_PM_DEF_BIT];
      slot_budget_action_q <= cfg_wdata_i[BUDGET_HI:BUDGET_LO];
    end
  end

  // ***************************************************************
  // Read path
  // ***************************************************************
  // Upper half from state, reserved as zero, lower half not held here
  always_comb begin
    cfg_rdata_o = '0;
    if (cfg_rd_i && cfg_addr_i == GEN_CTL_OFFSET) begin
      cfg_rdata_o[RETRY_HI:RETRY_LO] = cfg_retry_timeout_sel_q;
      cfg_rdata_o[RSVD_HI:RSVD_LO] = RSVD_VALUE;  // see R2
      cfg_rdata_o[LOW_SWING_BIT] = low_swing_q;
      cfg_rdata_o[PM_REV_BIT] = pm_rev_select_q;
      cfg_rdata_o[STRICT_BIT] = strict_q;
      cfg_rdata_o[PREFETCH_BIT] = upstream_prefetch_read_force_q;
      cfg_rdata_o[LINK_PM_DEF_BIT] = link_pm_default_sel_q;
      cfg_rdata_o[BUDGET_HI:BUDGET_LO] = slot_budget_action_q;
    end
  end

  // ***************************************************************
  // Retry timeout
  // ***************************************************************
  // Select the cycle count for the programmed timeout
  always_comb begin
    unique case (retry_sel_type'(cfg_retry_timeout_sel_q))  // see R1
      RETRY_25US: retry_limit = RETRY_W'(CYC_25US);
      RETRY_1MS: retry_limit = RETRY_W'(CYC_1MS);
      RETRY_25MS: retry_limit = RETRY_W'(CYC_25MS);
      RETRY_50MS: retry_limit = RETRY_W'(CYC_50MS);
    endcase
  end

  // Countdown that ends a retried configuration request
  retry_timer #(
    .CNT_W(RETRY_W)
  ) u_retry (
    .core_clk_i(core_clk_i),
    .reset_n_i(!any_reset),
    .start_i(retry_start_i),
    .abort_i(retry_done_i),
    .limit_i(retry_limit),
    .expired_o(retry_expired_o)
  );

  // ***************************************************************
  // Field effects
  // ***************************************************************
  // Transmitter swing follows the bit directly
  assign tx_low_swing_o = low_swing_q;  // see R3

  // Revision select drives version and soft-reset report
  assign pm_rev_field_o = pm_rev_select_q ? PM_REV_NEW : PM_REV_OLD;  // see R4
  assign pm_no_soft_reset_o = pm_rev_select_q;  // see R4

  // Strict bit picks the default group size
  assign low_prio_default_o = strict_q ? LOW_PRIO_STRICT
    : LOW_PRIO_DEFAULT;  // see R6
  // Extended channel wins only in strict mode with group size zero
  assign ext_vc_priority_o = strict_q
    && (low_prio_count_i == LOW_PRIO_STRICT);  // see R5

  // Forced prefetch turns every upstream read into multiple-line
  assign upstream_prefetch_read_force_o = upstream_prefetch_read_force_q;
  assign treat_as_multiple_o = up_mem_read_i
    && upstream_prefetch_read_force_q;  // see R7

  // Power-up value of the link power-state control field
  assign link_pm_control_o = link_pm_default_sel_q ? LINK_PM_BOTH
    : LINK_PM_OFF;  // see R8

  // ***************************************************************
  // Slot power budget
  // ***************************************************************
  logic ur_mode;  // Unsupported-request mode active

  budget_decode u_budget (
    .action_i(slot_budget_action_q),
    .short_i(slot_power_short_i),
    .signal_o(budget_exceeded_out_o),  // see R9
    .clkstop_o(sec_clk_stop_o),
    .ur_mode_o(ur_mode)
  );

  // Config requests and power-limit messages are still served
  assign req_unsupported_o = ur_mode && !req_is_cfg_i
    && !req_is_spl_i;  // see R10

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (any_reset);

  rsvd_read_zero_a: assert property (cfg_rdata_o[RSVD_HI:RSVD_LO] == 2'h0)  // see R2
    else $error("reserved bits read nonzero");
  pm_rev_a: assert property (pm_rev_field_o == (pm_no_soft_reset_o ? 3'h3 : 3'h2))  // see R4
    else $error("version and soft-reset flag disagree");
  strict_grant_a: assert property (ext_vc_priority_o |-> strict_q && low_prio_count_i == 3'h0)  // see R5
    else $error("extended channel granted outside strict mode");
  low_prio_def_a: assert property (low_prio_default_o == (strict_q ? 3'h0 : 3'h1))  // see R6
    else $error("wrong low priority default");
  prefetch_a: assert property (up_mem_read_i && upstream_prefetch_read_force_q |-> treat_as_multiple_o)  // see R7
    else $error("forced prefetch not applied");
  link_pm_a: assert property (link_pm_control_o == (link_pm_default_sel_q ? 2'h3 : 2'h0))  // see R8
    else $error("wrong link power default");
  budget_out_a: assert property (slot_power_short_i && slot_budget_action_q == 3'h1 |-> budget_exceeded_out_o && !sec_clk_stop_o)  // see R9
    else $error("budget signal action wrong");
  ur_a: assert property (slot_power_short_i && slot_budget_action_q == 3'h4 && req_is_cfg_i |-> !req_unsupported_o)  // see R10
    else $error("config request refused");
  write_apply_a: assert property (hit_wr && cfg_be_i[3] |=> low_swing_q == $past(cfg_wdata_i[27]))  // see R12
    else $error("write not applied next cycle");
  retry_sel_a: assert property (retry_start_i && !retry_done_i && cfg_retry_timeout_sel_q == 2'h0 ##1 !retry_done_i [*3] |-> !retry_expired_o)  // see R1
    else $error("retry expired too early");

  budget_both_c: cover property (budget_exceeded_out_o && sec_clk_stop_o);
  ur_c: cover property (req_unsupported_o);
  retry_c: cover property (retry_expired_o);

endmodule
`default_nettype wire

// File: tb/far_side_model.sv
// Far-side model: the upstream request source behind the bridge.
// Assumes the bench picks a request kind; 0 none, 1 memory read,
// 2 configuration request, 3 slot power limit message.
`timescale 1ns/100ps
`default_nettype none
module far_side_model (
  input wire logic [1:0] kind_i,
  output logic up_mem_read_o,
  output logic req_is_cfg_o,
  output logic req_is_spl_o
);
  // ***************************************************************
  // Request decode
  // ***************************************************************
  // One request kind at a time, so the qualifiers never overlap
  assign up_mem_read_o = (kind_i == 2'h1);
  assign req_is_cfg_o = (kind_i == 2'h2);
  assign req_is_spl_o = (kind_i == 2'h3);
endmodule
`default_nettype wire

// File: tb/bridge_general_control_reg_tb.sv
// Self-checking bench for the upper general control register half.
// Assumes combinational read data and field outputs one cycle on.
`timescale 1ns/100ps
`default_nettype none
module bridge_general_control_reg_tb;
  import gen_ctl_pkg::*;
  logic core_clk_i, wr, rd, start, done, short;
  logic [3:0] resets_n; // Core, fundamental, global, power-on
  logic [11:0] addr;
  logic [3:0] be;
  logic [31:0] wdata, rdata;
  logic [2:0] prio_cnt, bud;
  logic [1:0] kind;
  logic expired, swing, nosr, force_o, mult, extvc, mem, cfg, spl;
  logic clkstop, exceeded, unsup;
  logic [2:0] pmrev, lpdef;
  logic [1:0] lpm;
  logic [31:0] outs;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;
  assign outs = {21'h0, swing, pmrev, nosr, lpdef, lpm, force_o};
  assign bud = {exceeded, clkstop, unsup};

  // ***************************************************************
  // Design, far side and clock
  // ***************************************************************
  bridge_general_control_reg i_bridge_general_control_reg (
    .core_clk_i(core_clk_i), .reset_n_i(resets_n[0]),
    .fund_reset_n_i(resets_n[1]), .global_reset_in_n_i(resets_n[2]),
    .por_n_i(resets_n[3]), .cfg_wr_i(wr), .cfg_rd_i(rd),
    .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wdata),
    .cfg_rdata_o(rdata), .retry_start_i(start), .retry_done_i(done),
    .retry_expired_o(expired), .tx_low_swing_o(swing),
    .pm_rev_field_o(pmrev), .pm_no_soft_reset_o(nosr),
    .low_prio_count_i(prio_cnt), .low_prio_default_o(lpdef),
    .ext_vc_priority_o(extvc), .up_mem_read_i(mem),
    .upstream_prefetch_read_force_o(force_o),
    .treat_as_multiple_o(mult), .link_pm_control_o(lpm),
    .slot_power_short_i(short), .budget_exceeded_out_o(exceeded),
    .sec_clk_stop_o(clkstop), .req_is_cfg_i(cfg), .req_is_spl_i(spl),
    .req_unsupported_o(unsup));
  far_side_model i_far_side_model (.kind_i(kind),
    .up_mem_read_o(mem), .req_is_cfg_o(cfg), .req_is_spl_o(spl));
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  // Cuts a hang short
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  // ***************************************************************
  // Access tasks
  // ***************************************************************
  task automatic chk(input logic [31:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s %h", $time, what, got);
    end
  endtask
  // One-cycle write strobe
  task automatic wrt(input logic [11:0] a, input logic [3:0] b,
                     input logic [31:0] d);
    @(posedge core_clk_i);
    wr <= 1'b1; addr <= a; be <= b; wdata <= d;
    @(posedge core_clk_i);
    wr <= 1'b0;
  endtask
  // Read held for one cycle, data sampled mid-cycle
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    @(posedge core_clk_i);
    rd <= 1'b1; addr <= a;
    @(negedge core_clk_i);
    chk(rdata, exp, "read data");
    @(posedge core_clk_i);
    rd <= 1'b0;
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  initial begin
    {wr, rd, start, done, short} = '0;
    resets_n = 4'h0; addr = '0; be = '0; wdata = '0;
    prio_cnt = '0; kind = '0;
    repeat (3) @(posedge core_clk_i);
    resets_n <= 4'hf;
    rdc(12'h0d4, 32'h82000000);
    chk(outs, 32'h100, "defaults");
    wrt(12'h0d4, 4'hf, 32'hffffffff);
    rdc(12'h0d4, 32'hcff00000);
    chk(outs, 32'h5c7, "all set");
    wrt(12'h0d8, 4'hf, 32'h0);
    rdc(12'h0d4, 32'hcff00000);
    rdc(12'h0d8, 32'h0);
    wrt(12'h0d4, 4'h8, 32'h0);
    rdc(12'h0d4, 32'h00f00000);
    chk(outs, 32'h10e, "upper byte clear");
    // Strict grant and forced prefetch against group size and reads
    wrt(12'h0d4, 4'h8, 32'h03000000);
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk_i);
      prio_cnt <= i[2:0]; kind <= (i[1] ? 2'h1 : 2'h0);
      @(negedge core_clk_i);
      chk(extvc, (i == 0), "strict grant");
      chk(mult, i[1], "multiple read");
    end
    // Budget codes 0 to 4 with and without shortfall and request kind
    for (int c = 0; c < 5; c++) begin
      wrt(12'h0d4, 4'h4, 32'(c) << 20);
      for (int k = 0; k < 8; k++) begin
        @(posedge core_clk_i);
        short <= k[0]; kind <= (k[2:1] == 2'h1) ? 2'h0 : k[2:1];
        @(negedge core_clk_i);
        chk(bud, {k[0] && (c == 1 || c == 3), k[0] && (c == 2 || c == 3),
          k[0] && c == 4 && (kind == 0 || kind == 1)}, "budget");
      end
    end
    // Shortest retry time, then an aborted retry
    @(posedge core_clk_i);
    start <= 1'b1;
    @(posedge core_clk_i);
    start <= 1'b0;
    n = 0;
    @(negedge core_clk_i);
    while (expired !== 1'b1 && n < 4000) begin
      @(negedge core_clk_i);
      n++;
    end
    chk(n, CYC_25US, "retry time");
    @(posedge core_clk_i);
    start <= 1'b1;
    @(posedge core_clk_i);
    start <= 1'b0;
    repeat (9) @(posedge core_clk_i);
    done <= 1'b1;
    @(posedge core_clk_i);
    done <= 1'b0;
    n = 0;
    repeat (3300) @(negedge core_clk_i) if (expired === 1'b1) n++;
    chk(n, 0, "retry abort");
    // Each reset source restores the defaults
    for (int i = 0; i < 4; i++) begin
      wrt(12'h0d4, 4'hf, 32'hffffffff);
      @(posedge core_clk_i);
      resets_n[i] <= 1'b0;
      @(posedge core_clk_i);
      resets_n[i] <= 1'b1;
      rdc(12'h0d4, 32'h82000000);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
